//--- core/ssup_dip.sv
// Periodic voltage-dip test of the safety outputs with readback check
`timescale 1ns/1ps
`default_nettype none
`include "ssup_params.svh"
module ssup_dip
    import ssup_pkg::*;
#(
    parameter int DIP_PERIOD = `SSUP_DIP_PERIOD_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Requested outputs and pin readback
    input wire ssup_dip_req_type req,
    input wire logic [3:0] readback,
    // Driven pins and result
    output logic [3:0] pins,
    output ssup_dip_result_type result
);
    localparam int DIP_LEN = (`SSUP_DIP_CYCLES < 1) ? 1 : `SSUP_DIP_CYCLES;

    logic [31:0] period_q;
    logic [15:0] dip_cnt_q;
    logic dipping_q;
    logic [1:0] index_q;
    logic [3:0] pins_q;
    logic fail_q;

    wire logic period_done = (period_q >= 32'(DIP_PERIOD - 1));
    wire logic dip_last = dipping_q && (dip_cnt_q == 16'(DIP_LEN - 1));
    wire logic [3:0] dip_mask = dipping_q ? (4'h1 << index_q) : 4'h0;
    wire logic [3:0] other = pins_q & ~dip_mask;
    // Active output pulled to 0 V for a few microseconds
    wire logic [3:0] pins_d = req.demand & ~((req.dip_en && dipping_q) ? dip_mask : 4'h0); // [RL10]
    // Tested pin must read low, every other pin must read its drive
    wire logic bad_dip = dip_last && req.demand[index_q]
        && (readback[index_q] || ((readback & ~dip_mask) != other)); // [RL11] [RL12]
    wire logic bad_start = req.dip_en && period_done && ((readback & pins_q) != pins_q); // [RL12]

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            period_q <= 32'h0000_0000;
        else if (period_done || !req.dip_en)
            period_q <= 32'h0000_0000;
        else
            period_q <= period_q + 32'h0000_0001;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dipping_q <= 1'b0;
            dip_cnt_q <= 16'h0000;
            index_q <= 2'h0;
        end
        else if (dip_last || !req.dip_en)
        begin
            dipping_q <= 1'b0;
            dip_cnt_q <= 16'h0000;
            index_q <= dip_last ? index_q + 2'h1 : index_q;
        end
        else if (period_done)
            dipping_q <= 1'b1;
        else if (dipping_q)
            dip_cnt_q <= dip_cnt_q + 16'h0001;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pins_q <= 4'h0;
            fail_q <= 1'b0;
        end
        else
        begin
            pins_q <= pins_d;
            fail_q <= bad_dip || bad_start;
        end
    end

    assign pins = pins_q;
    assign result = '{fail: fail_q, index: index_q};
endmodule
`default_nettype wire

//--- core/ssup_params.svh
// Constants of the safety I/O supervisor: offsets, fields, resets, timing
`ifndef SSUP_PARAMS_SVH
`define SSUP_PARAMS_SVH

// Register byte offsets
`define SSUP_CTRL_OFS 12'h000
`define SSUP_RESTART_OFS 12'h004
`define SSUP_STSEL_OFS 12'h008
`define SSUP_NODE_OFS 12'h00c
`define SSUP_STATUS_OFS 12'h010
`define SSUP_FAULT_OFS 12'h014

// Control fields
`define SSUP_CTRL_DEMAND_LSB 0
`define SSUP_CTRL_DIP_EN_BIT 4
`define SSUP_CTRL_TEST_EN_BIT 5
`define SSUP_CTRL_GROUP_LSB 6

// Reset values
`define SSUP_CTRL_RST 32'h0000_0030
`define SSUP_RESTART_RST 8'h00
`define SSUP_STSEL_RST 16'h0000
`define SSUP_NODE_RST 4'h0

// Timing
`define SSUP_CLK_PERIOD_NS 100
`define SSUP_DIP_TIME_NS 2000
`define SSUP_DIP_PERIOD_US 10000
`define SSUP_TEST_LOW_NS 5000
`define SSUP_TEST_PERIOD_US 1000
`define SSUP_DIP_CYCLES (`SSUP_DIP_TIME_NS / `SSUP_CLK_PERIOD_NS)
`define SSUP_DIP_PERIOD_CYCLES (`SSUP_DIP_PERIOD_US * 1000 / `SSUP_CLK_PERIOD_NS)
`define SSUP_TEST_LOW_CYCLES (`SSUP_TEST_LOW_NS / `SSUP_CLK_PERIOD_NS)
`define SSUP_TEST_PERIOD_CYCLES (`SSUP_TEST_PERIOD_US * 1000 / `SSUP_CLK_PERIOD_NS)

`endif

//--- core/ssup_pkg.sv
// Types of the safety I/O supervisor
package ssup_pkg;

    typedef enum logic [1:0] {
        SSUP_RESTART_AUTO,
        SSUP_RESTART_MANUAL,
        SSUP_RESTART_MONITORED,
        SSUP_RESTART_RSVD
    } ssup_restart_mode_type;

    typedef enum logic [1:0] {
        SSUP_GROUP_FOUR_SINGLE,
        SSUP_GROUP_TWO_DUAL,
        SSUP_GROUP_DUAL_TWO_SINGLE,
        SSUP_GROUP_RSVD
    } ssup_group_type;

    typedef struct packed {
        logic dip_en;
        logic [3:0] demand;
    } ssup_dip_req_type;

    typedef struct packed {
        logic fail;
        logic [1:0] index;
    } ssup_dip_result_type;

endpackage

//--- core/ssup_restart.sv
// Restart and contactor feedback supervision for one output channel
`timescale 1ns/1ps
`default_nettype none
module ssup_restart
    import ssup_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Channel control
    input wire logic [1:0] mode,
    input wire logic demand,
    input wire logic restart_fbk,
    // Result
    output logic active
);
    typedef enum logic [1:0] {
        SSUP_R_OFF,
        SSUP_R_LOW_SEEN,
        SSUP_R_HIGH_SEEN,
        SSUP_R_ON
    } ssup_rstate_type;

    ssup_rstate_type state_q;
    ssup_rstate_type state_d;
    logic active_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SSUP_R_OFF:
            begin
                if (demand && mode == SSUP_RESTART_AUTO && restart_fbk)
                    state_d = SSUP_R_ON; // [RL17]
                else if (demand && !restart_fbk)
                    state_d = SSUP_R_LOW_SEEN;
            end
            SSUP_R_LOW_SEEN:
            begin
                if (!demand)
                    state_d = SSUP_R_OFF;
                else if (restart_fbk && mode == SSUP_RESTART_MONITORED)
                    state_d = SSUP_R_HIGH_SEEN; // [RL16]
                else if (restart_fbk && mode != SSUP_RESTART_RSVD)
                    state_d = SSUP_R_ON; // [RL15] [RL17]
            end
            SSUP_R_HIGH_SEEN:
            begin
                if (!demand)
                    state_d = SSUP_R_OFF;
                else if (!restart_fbk)
                    state_d = SSUP_R_ON; // [RL16]
            end
            SSUP_R_ON:
            begin
                if (!demand)
                    state_d = SSUP_R_OFF;
                else if (mode == SSUP_RESTART_AUTO && !restart_fbk)
                    state_d = SSUP_R_OFF; // [RL17]
            end
            default:
                state_d = SSUP_R_OFF;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= SSUP_R_OFF;
            active_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            active_q <= (state_d == SSUP_R_ON); // [RL7]
        end
    end

    assign active = active_q;
endmodule
`default_nettype wire

//--- core/ssup_top.sv
// Safety I/O supervisor: enables, node address, restart, test and dip logic
`timescale 1ns/1ps
`default_nettype none
`include "ssup_params.svh"
// Function
// RL1: Run only while both permits held high
// RL2: Permits low disable normal operation
// RL3: Variant without permits is always enabled
// RL4: Node address from two select inputs
// RL5: At most four node addresses
// RL6: Installer never duplicates node address
// RL7: Restart input checks feedback and restart
// RL8: Status output shows input, output or node
// RL9: Test outputs detect shorts, four inputs each
// RL10: Periodic microsecond dip on active outputs
// RL11: Dip mismatch forces safe state at once
// RL12: Detect stuck low, stuck high, shorted outputs
// RL13: Four single, two dual, or mixed grouping
// RL14: Dual channel shares one feedback input
// RL15: Manual restart needs low-to-high transition
// RL16: Monitored restart needs low-high-low pulse
// RL17: Automatic restart while input held high
// RL18: Safe state holds outputs off until reset
module ssup_top
    import ssup_pkg::*;
#(
    parameter bit HAS_PERMIT = 1'b1,
    parameter int NUM_IN = 8,
    parameter int NUM_TEST = 2,
    parameter int NUM_STATUS = 4,
    parameter int DIP_PERIOD = `SSUP_DIP_PERIOD_CYCLES,
    parameter int TEST_PERIOD = `SSUP_TEST_PERIOD_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Enable and address straps
    input wire logic run_permit_a,
    input wire logic run_permit_b,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    // Field inputs and test outputs
    input wire logic [NUM_IN-1:0] field_in,
    output logic [NUM_TEST-1:0] test_out,
    // Safety outputs and feedback
    input wire logic [3:0] restart_fbk,
    input wire logic [3:0] output_readback,
    output logic [3:0] safety_switch_output,
    // Status outputs and state
    output logic [NUM_STATUS-1:0] status_out,
    output logic [1:0] node_addr,
    output logic enabled,
    output logic safe_state
);
    localparam int TEST_LOW = (`SSUP_TEST_LOW_CYCLES < 1) ? 1 : `SSUP_TEST_LOW_CYCLES;
    localparam int SRC_W = NUM_IN + 8;

    // Register state
    logic [31:0] ctrl_q;
    logic [7:0] restart_q;
    logic [15:0] stsel_q;
    logic [3:0] node_q;
    logic [NUM_IN-1:0] short_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Block state
    logic enabled_q;
    logic [1:0] node_addr_q;
    logic safe_q;
    logic [31:0] test_cnt_q;
    logic [NUM_TEST-1:0] test_out_q;
    logic [NUM_STATUS-1:0] status_q;
    logic [3:0] chan_active;
    logic [3:0] dip_pins;
    ssup_dip_result_type dip_result;

    // Selects one bit of the status source vector
    function automatic logic pick_bit(input logic [SRC_W-1:0] src, input logic [3:0] sel);
        logic r;
        r = 1'b0;
        if (32'(sel) < SRC_W)
            r = src[sel];
        return r;
    endfunction

    // Compares an APB address with a register offset
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        return (a == ofs);
    endfunction

    // APB decode
    wire logic setup_ph = psel && !penable;
    wire logic wr_en = psel && penable && pready_q && pwrite;
    wire logic hit_ctrl = addr_is(paddr, `SSUP_CTRL_OFS);
    wire logic hit_restart = addr_is(paddr, `SSUP_RESTART_OFS);
    wire logic hit_stsel = addr_is(paddr, `SSUP_STSEL_OFS);
    wire logic hit_node = addr_is(paddr, `SSUP_NODE_OFS);
    wire logic hit_status = addr_is(paddr, `SSUP_STATUS_OFS);
    wire logic hit_fault = addr_is(paddr, `SSUP_FAULT_OFS);
    wire logic hit_any = hit_ctrl || hit_restart || hit_stsel || hit_node || hit_status
        || hit_fault;

    // Control fields
    wire logic [3:0] demand_reg = ctrl_q[`SSUP_CTRL_DEMAND_LSB +: 4];
    wire logic dip_en = ctrl_q[`SSUP_CTRL_DIP_EN_BIT];
    wire logic test_en = ctrl_q[`SSUP_CTRL_TEST_EN_BIT];
    wire ssup_group_type group = ssup_group_type'(ctrl_q[`SSUP_CTRL_GROUP_LSB +: 2]);

    // Enable gating
    wire logic permit_ok = HAS_PERMIT ? (run_permit_a && run_permit_b) : 1'b1; // [RL1] [RL2] [RL3]

    // Channel grouping: dual pairs follow the even channel
    wire logic pair_lo = (group == SSUP_GROUP_TWO_DUAL) || (group == SSUP_GROUP_DUAL_TWO_SINGLE); // [RL13]
    wire logic pair_hi = (group == SSUP_GROUP_TWO_DUAL); // [RL13]
    wire logic [3:0] chan_demand_raw = demand_reg & {4{enabled_q && !safe_q}}; // [RL2] [RL18]
    wire logic [3:0] chan_demand = {pair_hi ? chan_demand_raw[2] : chan_demand_raw[3],
        chan_demand_raw[2], pair_lo ? chan_demand_raw[0] : chan_demand_raw[1],
        chan_demand_raw[0]}; // [RL14]
    wire logic [3:0] chan_fbk = {pair_hi ? restart_fbk[2] : restart_fbk[3], restart_fbk[2],
        pair_lo ? restart_fbk[0] : restart_fbk[1], restart_fbk[0]}; // [RL14]
    wire logic [7:0] chan_mode = {pair_hi ? restart_q[5:4] : restart_q[7:6], restart_q[5:4],
        pair_lo ? restart_q[1:0] : restart_q[3:2], restart_q[1:0]};

    // Test output sequencing
    wire logic test_wrap = (test_cnt_q >= 32'(TEST_PERIOD - 1));
    wire logic test_low = test_en && (test_cnt_q < 32'(TEST_LOW));
    wire logic test_check = test_en && (test_cnt_q == 32'(TEST_LOW - 1));
    logic [NUM_IN-1:0] short_set;
    always_comb
    begin
        short_set = '0;
        for (int i = 0; i < NUM_IN; i++)
            short_set[i] = test_check && field_in[i]; // [RL9]
    end
    wire logic [NUM_IN-1:0] clean_in = field_in & ~short_q;

    // Status sources
    wire logic [SRC_W-1:0] status_src = {node_q, safety_switch_output, clean_in};
    logic [NUM_STATUS-1:0] status_d;
    always_comb
    begin
        status_d = '0;
        for (int s = 0; s < NUM_STATUS; s++)
            status_d[s] = pick_bit(status_src, stsel_q[4*s +: 4]); // [RL8]
    end

    // Read data
    wire logic [31:0] status_word = {17'h0_0000, dip_result.index, test_en, chan_active,
        safe_q, enabled_q, safety_switch_output, node_addr_q};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_q
        : hit_restart ? {24'h00_0000, restart_q}
        : hit_stsel ? {16'h0000, stsel_q}
        : hit_node ? {28'h000_0000, node_q}
        : hit_status ? status_word
        : hit_fault ? 32'(short_q)
        : 32'h0000_0000;

    ssup_restart u_restart[3:0]
    (
        .clock(clock),
        .rst_b(rst_b),
        .mode(chan_mode),
        .demand(chan_demand),
        .restart_fbk(chan_fbk),
        .active(chan_active)
    );

    // Dip request: only active channels outside the safe state
    wire ssup_dip_req_type dip_req = '{dip_en: dip_en, demand: chan_active & {4{!safe_q}}};

    ssup_dip #(
        .DIP_PERIOD(DIP_PERIOD)
    ) u_dip
    (
        .clock(clock),
        .rst_b(rst_b),
        .req(dip_req),
        .readback(output_readback),
        .pins(dip_pins),
        .result(dip_result)
    );

    // APB response
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !hit_any;
            prdata_q <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Writable registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= `SSUP_CTRL_RST;
            restart_q <= `SSUP_RESTART_RST;
            stsel_q <= `SSUP_STSEL_RST;
            node_q <= `SSUP_NODE_RST;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl_q <= {24'h00_0000, pwdata[7:0]};
            if (hit_restart)
                restart_q <= pwdata[7:0];
            if (hit_stsel)
                stsel_q <= pwdata[15:0];
            if (hit_node)
                node_q <= pwdata[3:0];
        end
    end

    // Input short flags: set wins over write-one-to-clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            short_q <= '0;
        else
            short_q <= (short_q & ~((wr_en && hit_fault) ? pwdata[NUM_IN-1:0] : '0))
                | short_set; // [RL9]
    end

    // Enable and node address sampling
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enabled_q <= 1'b0;
            node_addr_q <= 2'h0;
        end
        else
        begin
            enabled_q <= permit_ok; // [RL1] [RL2] [RL3]
            node_addr_q <= {addr_select_bit1, addr_select_bit0}; // [RL4] [RL5]
        end
    end

    // Latched safe state after a failed dip test
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            safe_q <= 1'b0;
        else if (dip_result.fail)
            safe_q <= 1'b1; // [RL11] [RL18]
    end

    // Test output generator
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            test_cnt_q <= 32'h0000_0000;
            test_out_q <= '1;
        end
        else
        begin
            test_cnt_q <= (test_wrap || !test_en) ? 32'h0000_0000 : test_cnt_q + 32'h0000_0001;
            test_out_q <= {NUM_TEST{!test_low}}; // [RL9]
        end
    end

    // Status outputs
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            status_q <= '0;
        else
            status_q <= status_d; // [RL8]
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign test_out = test_out_q;
    assign safety_switch_output = dip_pins; // [RL10] [RL18]
    assign status_out = status_q;
    assign node_addr = node_addr_q;
    assign enabled = enabled_q;
    assign safe_state = safe_q;
endmodule
`default_nettype wire

//--- verif/safety_io_supervisor_test.sv
// Self-checking bench of the safety I/O supervisor
`timescale 1ns/1ps
`default_nettype none
module safety_io_supervisor_test;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, e, pa, pb, s0, s1, slow, en, safe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] fbk, rb, sso, stk_lo, stk_hi, st;
    logic [7:0] fin, son, shi;
    logic [1:0] tst, node;
    int mismatches = 0;
    int n_tests = 0;

    ssup_top #(.DIP_PERIOD(200), .TEST_PERIOD(100)) u_ssup_top (.clock, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_permit_a(pa),
        .run_permit_b(pb), .addr_select_bit0(s0), .addr_select_bit1(s1), .field_in(fin),
        .test_out(tst), .restart_fbk(fbk), .output_readback(rb), .safety_switch_output(sso),
        .status_out(st), .node_addr(node), .enabled(en), .safe_state(safe));
    ssup_field_model u_ssup_field_model (.clock, .pins(sso), .test_out(tst), .slow,
        .stuck_lo(stk_lo), .stuck_hi(stk_hi), .sensor_on(son), .short_hi(shi),
        .readback(rb), .field_in(fin));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, read data left in d and error in e
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            end_sim;
        end
    endtask

    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, s0, s1, fbk, slow} = '0;
        {stk_lo, stk_hi, son, shi} = '0;
        {pa, pb} = 2'b11;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(d, i == 0 ? 32'h30 : 32'h0);
        end
        apb(1'b0, 12'h018, 32'h0);
        check({d[30:0], e}, 32'h1);
        $display("reset and map test done");
        // One unit only, so its address is unique
        for (int k = 0; k < 4; k++)
        begin
            {s1, s0} <= 2'(k);
            repeat (3) @(posedge clock);
            check(32'(node), 32'(k));
            apb(1'b0, 12'h010, 32'h0);
            check(d & 32'h10c3, 32'h1040 | 32'(k));
        end
        $display("node address test done");
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, 12'h000, 32'h20);
            apb(1'b1, 12'h004, 32'({4{2'(m)}}));
            apb(1'b1, 12'h000, 32'h2f);
            for (int p = 0; p < 3; p++)
            begin
                fbk <= p[0] ? 4'hf : 4'h0;
                repeat (30) @(posedge clock);
                check(32'(sso), (p == 1 && m < 2) || (p == 2 && (m == 1 || m == 2))
                    ? 32'hf : 32'h0);
            end
        end
        $display("restart mode test done");
        apb(1'b1, 12'h004, 32'h0);
        fbk <= 4'h5;
        for (int g = 0; g < 4; g++)
        begin
            apb(1'b1, 12'h000, 32'h25 | 32'(g << 6));
            repeat (30) @(posedge clock);
            check(32'(sso), g == 1 ? 32'hf : g == 2 ? 32'h7 : 32'h5);
        end
        $display("grouping test done");
        apb(1'b1, 12'h008, 32'hd9c8);
        apb(1'b1, 12'h00c, 32'h1);
        repeat (3) @(posedge clock);
        check(32'(st), 32'h3);
        apb(1'b1, 12'h00c, 32'h2);
        repeat (3) @(posedge clock);
        check(32'(st), 32'h9);
        $display("status output test done");
        for (int k = 0; k < 4; k++)
        begin
            {pa, pb} <= 2'(k);
            repeat (30) @(posedge clock);
            check(32'(en), 32'(k == 3));
            check(32'(sso), k == 3 ? 32'h5 : 32'h0);
        end
        $display("permit test done");
        son <= 8'hff;
        shi <= 8'h10;
        apb(1'b1, 12'h014, 32'hff);
        repeat (250) @(posedge clock);
        apb(1'b0, 12'h014, 32'h0);
        check(d, 32'h10);
        shi <= 8'h00;
        apb(1'b1, 12'h014, 32'hff);
        repeat (250) @(posedge clock);
        apb(1'b0, 12'h014, 32'h0);
        check(d, 32'h0);
        $display("short detect test done");
        slow <= 1'b1;
        apb(1'b1, 12'h000, 32'h3f);
        repeat (900) @(posedge clock);
        check(32'(safe), 32'h0);
        stk_lo <= 4'h4;
        repeat (500) @(posedge clock);
        check(32'(safe), 32'h1);
        stk_lo <= 4'h0;
        repeat (50) @(posedge clock);
        check(32'({safe, sso}), 32'h10);
        rst_b <= 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (30) @(posedge clock);
        fbk <= 4'hf;
        stk_hi <= 4'h2;
        apb(1'b1, 12'h000, 32'h3d);
        repeat (900) @(posedge clock);
        check(32'({safe, sso}), 32'h10);
        $display("dip test done");
        end_sim;
    end
endmodule
`default_nettype wire

//--- verif/ssup_field_model.sv
// Field side model: output readback wiring, faults and test-output fed inputs
`timescale 1ns/1ps
`default_nettype none
module ssup_field_model
(
    // Clock
    input wire logic clock,
    // Pins from the block
    input wire logic [3:0] pins,
    input wire logic [1:0] test_out,
    // Wiring and fault controls
    input wire logic slow,
    input wire logic [3:0] stuck_lo,
    input wire logic [3:0] stuck_hi,
    input wire logic [7:0] sensor_on,
    input wire logic [7:0] short_hi,
    // Readback and field levels
    output logic [3:0] readback,
    output logic [7:0] field_in
);
    logic [3:0] pins_q;
    always_ff @(posedge clock)
    begin
        pins_q <= pins;
    end
    assign readback = ((slow ? pins_q : pins) & ~stuck_lo) | stuck_hi;
    // Four inputs per test output, parallel wiring
    assign field_in = ({{4{test_out[1]}}, {4{test_out[0]}}} & sensor_on) | short_hi;
endmodule
`default_nettype wire

//--- verif/ssup_top_props.sv
// Concurrent checks on the safety I/O supervisor ports
`timescale 1ns/1ps
`default_nettype none
module ssup_top_props
#(
    parameter int NUM_TEST = 2,
    parameter int DIP_PERIOD = 200
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Straps and state
    input wire logic run_permit_a,
    input wire logic run_permit_b,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic [1:0] node_addr,
    input wire logic enabled,
    input wire logic safe_state,
    // Pins
    input wire logic [NUM_TEST-1:0] test_out,
    input wire logic [3:0] output_readback,
    input wire logic [3:0] safety_switch_output
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    logic [7:0] lo_q;
    logic [7:0] dip_q;
    logic [15:0] mis_q;
    logic live_q;
    // Low run lengths and mismatch age
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lo_q <= 8'h0;
            dip_q <= 8'h0;
            mis_q <= 16'h0;
            live_q <= 1'b0;
        end
        else
        begin
            live_q <= 1'b1;
            lo_q <= test_out[0] ? 8'h0 : lo_q + {7'h0, lo_q != 8'hff};
            dip_q <= safety_switch_output[0] ? 8'h0 : dip_q + {7'h0, dip_q != 8'hff};
            mis_q <= (safety_switch_output != 4'h0 && output_readback != safety_switch_output)
                ? mis_q + 16'h1 : 16'h0;
        end
    end
    property p_run;
        live_q && run_permit_a && run_permit_b |=> enabled;
    endproperty
    a_run: assert property (p_run) else $error("enabled low with both permits");
    property p_stop;
        live_q && !(run_permit_a && run_permit_b) |=> !enabled;
    endproperty
    a_stop: assert property (p_stop) else $error("enabled high without permits");
    property p_off;
        (!enabled) [*6] |-> safety_switch_output == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("output on while disabled");
    property p_node;
        live_q |=> node_addr[1] == $past(addr_select_bit1)
            && node_addr[0] == $past(addr_select_bit0);
    endproperty
    a_node: assert property (p_node) else $error("node address wrong");
    property p_test_low;
        $rose(test_out[0]) |-> lo_q == 8'h32;
    endproperty
    a_test_low: assert property (p_test_low) else $error("test low length wrong");
    property p_dip;
        $rose(safety_switch_output[0]) && dip_q < 8'h19 |-> dip_q == 8'h14;
    endproperty
    a_dip: assert property (p_dip) else $error("dip length wrong");
    property p_mismatch;
        mis_q == 16'(4 * DIP_PERIOD) |-> safe_state;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("fault not caught");
    property p_sticky;
        safe_state |=> safe_state;
    endproperty
    a_sticky: assert property (p_sticky) else $error("safe state left");
    property p_safe_off;
        safe_state [*3] |-> safety_switch_output == 4'h0;
    endproperty
    a_safe_off: assert property (p_safe_off) else $error("output on in safe state");
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong");
    c_safe: cover property ($rose(safe_state));
    c_dip: cover property ($rose(safety_switch_output[0]) && dip_q == 8'h14);
    c_err: cover property (pslverr && pready);
endmodule
bind ssup_top ssup_top_props #(.NUM_TEST(NUM_TEST), .DIP_PERIOD(DIP_PERIOD)) u_ssup_top_props (
    .clock, .rst_b, .psel, .penable, .pready, .pslverr, .run_permit_a, .run_permit_b,
    .addr_select_bit0, .addr_select_bit1, .node_addr, .enabled, .safe_state, .test_out,
    .output_readback, .safety_switch_output);
`default_nettype wire
